// ---- rtl/itm_engine.sv ----
// itm_engine: apb-reached master transfer engine for a two-wire bus
// assumes open-drain pads with pull-ups and pins synchronous to pclk
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
module itm_engine
  import itm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  output logic             sda_out,
  output logic             sda_oe_n
);
  itm_state_e        st_q;
  logic [1:0]        step_q;
  logic [2:0]        bit_q;
  logic [7:0]        sh_q;
  logic [10:0]       buf_q;
  logic              phase_q;
  logic              scl_low_q;
  logic              sda_low_q;
  logic              addr_q;
  logic              dir_q;
  logic              rd_q;
  logic              rxm_q;
  logic              last_q;
  logic              en_q;
  logic              mst_q;
  logic              long_q;
  logic              general_call_enable_q;
  logic [OA_W-1:0]   oa_q;
  logic [BRT_W-1:0]  baud_q;
  logic [7:0]        txd_q;
  logic [7:0]        rxd_q;
  logic              tx_pend_q;
  logic              start_req_q;
  logic              stop_req_q;
  logic              nack_req_q;
  logic [FLG_N-1:0]  fl_q;
  logic [FLG_N-1:0]  fl_set;
  logic [FLG_N-1:0]  fl_clr;
  logic [31:0]       prdata_q;
  logic [31:0]       rdm;
  logic              wr;
  logic              rd;
  logic              hit;
  logic              wr_ctl;
  logic              wr_txd;
  logic              rd_rxd;
  logic              srst;
  logic              go;
  logic              tk;
  logic              ld_tx;
  logic              ld_rx;
  logic              ev_start_done;
  logic              ev_ack_ok;
  logic              ev_nack;
  logic              ev_rx_byte;
  logic              ev_stop_done;

  itm_brg_if bi ();

  itm_brg itm_brg_inst (
    .pclk    (pclk),
    .presetn (presetn),
    .bi      (bi)
  );

  // baud generator hookup, runs only while clocking the bus
  assign bi.run = (st_q == ST_START) || (st_q == ST_BIT) ||
                  (st_q == ST_ACK) || (st_q == ST_STOP);
  assign bi.div = baud_q;
  assign bi.gen_clk = !scl_low_q;
  assign bi.pin_clk = scl_in;
  assign tk = bi.tick;

  // apb decode, zero wait states
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign hit = (paddr == OFS_CTRL) || (paddr == OFS_BAUD) ||
               (paddr == OFS_FLAG) || (paddr == OFS_TXD) ||
               (paddr == OFS_RXD) || (paddr == OFS_MODE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;
  assign wr_ctl = wr && (paddr == OFS_CTRL);
  assign wr_txd = wr && (paddr == OFS_TXD);
  assign rd_rxd = rd && (paddr == OFS_RXD);
  assign srst = wr_ctl && pwdata[CTL_SRST];
  assign go = en_q && !srst;

  // open-drain pins: output level is always low
  assign scl_out = PIN_LOW;
  assign sda_out = PIN_LOW;
  assign scl_oe_n = !scl_low_q;
  assign sda_oe_n = !sda_low_q;

  // hold-state launches
  assign ld_rx = (st_q == ST_HOLD) && !stop_req_q && !start_req_q &&
                 rd_q && !last_q && !fl_q[FLG_RXF];
  assign ld_tx = (st_q == ST_HOLD) && !stop_req_q && !start_req_q &&
                 !rd_q && tx_pend_q;

  // engine events
  assign ev_start_done = go && (st_q == ST_START) && tk &&
                         (step_q == 2'h3);
  assign ev_ack_ok = go && (st_q == ST_ACK) && tk && phase_q &&
                     !rxm_q && !sda_in;
  assign ev_nack = go && (st_q == ST_ACK) && tk && phase_q &&
                   !rxm_q && sda_in;
  assign ev_rx_byte = go && (st_q == ST_BIT) && tk && phase_q &&
                      rxm_q && (bit_q == BIT_LAST);
  assign ev_stop_done = go && (st_q == ST_BUF) && (buf_q == 11'h000);

  // flag set and clear vectors
  always_comb
  begin
    fl_set = '0;
    fl_set[FLG_START] = ev_start_done;
    fl_set[FLG_STOP] = ev_stop_done;
    fl_set[FLG_NACK] = ev_nack;
    fl_set[FLG_TXE] = ev_start_done ||
                      (ev_ack_ok && !(addr_q && dir_q));
    fl_set[FLG_RXF] = ev_rx_byte;
    fl_clr = '0;
    fl_clr[FLG_START] = wr && (paddr == OFS_FLAG) && pwdata[FLG_START];
    fl_clr[FLG_STOP] = wr && (paddr == OFS_FLAG) && pwdata[FLG_STOP];
    fl_clr[FLG_NACK] = wr && (paddr == OFS_FLAG) && pwdata[FLG_NACK];
    fl_clr[FLG_TXE] = wr_txd;
    fl_clr[FLG_RXF] = rd_rxd;
  end

  // sticky flags, a set in the clearing cycle wins
  for (genvar i = 0; i < FLG_N; i++)
  begin : g_flag
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
        fl_q[i] <= 1'b0;
      else if (fl_set[i])
        fl_q[i] <= 1'b1;
      else if (fl_clr[i])
        fl_q[i] <= 1'b0;
    end
  end

  // configuration registers and transmit buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 1'b0;
      mst_q <= 1'b0;
      long_q <= 1'b0;
      general_call_enable_q <= 1'b0;
      oa_q <= '0;
      baud_q <= BRT_RST;
      txd_q <= 8'h00;
      tx_pend_q <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        en_q <= pwdata[CTL_EN];
        mst_q <= pwdata[CTL_MST];
      end
      if (wr && (paddr == OFS_BAUD))
        baud_q <= pwdata[BRT_W-1:0];
      if (wr && (paddr == OFS_MODE))
      begin
        long_q <= pwdata[MODE_LONG];
        general_call_enable_q <= pwdata[MODE_GENERAL_CALL_ENABLE];
        oa_q <= pwdata[MODE_OA +: OA_W];
      end
      if (wr_txd)
        txd_q <= pwdata[7:0];
      if (wr_txd)
        tx_pend_q <= 1'b1;
      else if (srst || ld_tx)
        tx_pend_q <= 1'b0;
    end
  end

  // request bits: software sets, engine clears
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      {start_req_q, stop_req_q, nack_req_q} <= 3'h0;
    else if (srst || !en_q)
      {start_req_q, stop_req_q, nack_req_q} <= 3'h0;
    else
    begin
      if (ev_start_done)
        start_req_q <= 1'b0;
      else if (wr_ctl && pwdata[CTL_STA])
        start_req_q <= 1'b1;
      if (ev_stop_done || (st_q == ST_IDLE))
        stop_req_q <= 1'b0;
      else if (wr_ctl && pwdata[CTL_STO])
        stop_req_q <= 1'b1;
      if (ev_rx_byte)
        nack_req_q <= 1'b0;
      else if (wr_ctl && pwdata[CTL_NAK])
        nack_req_q <= 1'b1;
    end
  end

  // received byte capture
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rxd_q <= 8'h00;
    else if (ev_rx_byte)
      rxd_q <= {sh_q[6:0], sda_in};
  end

  // transfer state machine and line drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_IDLE;
      {step_q, bit_q, sh_q, buf_q} <= '0;
      {phase_q, scl_low_q, sda_low_q, addr_q} <= 4'h0;
      {dir_q, rd_q, rxm_q, last_q} <= 4'h0;
    end
    else if (srst || !en_q)
    begin
      st_q <= ST_IDLE;
      {step_q, bit_q, sh_q, buf_q} <= '0;
      {phase_q, scl_low_q, sda_low_q, addr_q} <= 4'h0;
      {dir_q, rd_q, rxm_q, last_q} <= 4'h0;
    end
    else
    begin
      unique case (st_q)
        ST_IDLE:
          if (mst_q && start_req_q)
          begin
            st_q <= ST_START;
            step_q <= STEP_IDLE;
          end
        ST_START:
          if (tk)
          begin
            step_q <= step_q + 2'h1;
            case (step_q)
              2'h0: sda_low_q <= 1'b0;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b1;
              default:
              begin
                scl_low_q <= 1'b1;
                st_q <= ST_HOLD;
                addr_q <= 1'b1;
                rd_q <= 1'b0;
                last_q <= 1'b0;
              end
            endcase
          end
        ST_HOLD:
          // clock stays low here until software acts or an acked read address starts the first receive
          if (stop_req_q)
          begin
            st_q <= ST_STOP;
            step_q <= 2'h0;
          end
          else if (start_req_q)
          begin
            st_q <= ST_START;
            step_q <= STEP_RS;
          end
          else if (ld_rx)
          begin
            st_q <= ST_BIT;
            sh_q <= RX_FILL;
            rxm_q <= 1'b1;
            bit_q <= 3'h0;
            phase_q <= 1'b0;
            sda_low_q <= 1'b0;
          end
          else if (ld_tx)
          begin
            st_q <= ST_BIT;
            sh_q <= txd_q;
            dir_q <= txd_q[DIR_BIT];
            rxm_q <= 1'b0;
            bit_q <= 3'h0;
            phase_q <= 1'b0;
            sda_low_q <= !txd_q[7];
          end
        ST_BIT:
          if (tk)
          begin
            phase_q <= !phase_q;
            scl_low_q <= phase_q;
            if (phase_q)
            begin
              sh_q <= {sh_q[6:0], sda_in};
              if (bit_q == BIT_LAST)
              begin
                st_q <= ST_ACK;
                sda_low_q <= rxm_q && !nack_req_q;
                last_q <= rxm_q && nack_req_q;
              end
              else
              begin
                bit_q <= bit_q + 3'h1;
                sda_low_q <= !rxm_q && !sh_q[6];
              end
            end
          end
        ST_ACK:
          if (tk)
          begin
            phase_q <= !phase_q;
            scl_low_q <= phase_q;
            if (phase_q)
            begin
              st_q <= ST_HOLD;
              sda_low_q <= 1'b0;
              addr_q <= 1'b0;
              if (!rxm_q && !sda_in && addr_q && dir_q)
                rd_q <= 1'b1;
            end
          end
        ST_STOP:
          if (tk)
          begin
            step_q <= step_q + 2'h1;
            if (step_q == 2'h0)
              sda_low_q <= 1'b1;
            else if (step_q == 2'h1)
              scl_low_q <= 1'b0;
            else if (step_q == STEP_STO)
            begin
              sda_low_q <= 1'b0;
              st_q <= ST_BUF;
              buf_q <= TBUF_LAST;
            end
          end
        ST_BUF:
          // bus free time before the stop is reported
          if (buf_q == 11'h000)
            st_q <= ST_IDLE;
          else
            buf_q <= buf_q - 11'h001;
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end

  // read mux, latched in the setup cycle
  always_comb
  begin
    rdm = 32'h0000_0000;
    case (paddr)
      OFS_CTRL:
      begin
        rdm[CTL_EN] = en_q;
        rdm[CTL_MST] = mst_q;
        rdm[CTL_STA] = start_req_q;
        rdm[CTL_STO] = stop_req_q;
        rdm[CTL_NAK] = nack_req_q;
      end
      OFS_BAUD: rdm[BRT_W-1:0] = baud_q;
      OFS_FLAG:
      begin
        rdm[FLG_N-1:0] = fl_q;
        rdm[FLG_BUSY] = st_q != ST_IDLE;
      end
      OFS_TXD: rdm[7:0] = txd_q;
      OFS_RXD: rdm[7:0] = rxd_q;
      OFS_MODE:
      begin
        rdm[MODE_LONG] = long_q;
        rdm[MODE_GENERAL_CALL_ENABLE] = general_call_enable_q;
        rdm[MODE_OA +: OA_W] = oa_q;
      end
      default: rdm = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_q <= rdm;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_start;
    ev_start_done |=>
      fl_q[FLG_START] && fl_q[FLG_TXE] && !start_req_q;
  endproperty
  a_start: assert property (p_start)
    else $error("start completion flags wrong");

  property p_hold;
    st_q == ST_HOLD |-> !scl_oe_n;
  endproperty
  a_hold: assert property (p_hold)
    else $error("clock released while holding");

  property p_load;
    ld_tx && go |=> st_q == ST_BIT && sh_q == $past(txd_q)
      && sda_low_q == !sh_q[7];
  endproperty
  a_load: assert property (p_load)
    else $error("byte not loaded into shifter");

  property p_nack;
    ev_nack && !wr_txd |=> fl_q[FLG_NACK]
      && fl_q[FLG_TXE] == $past(fl_q[FLG_TXE]);
  endproperty
  a_nack: assert property (p_nack)
    else $error("nack handling wrong");

  property p_stop;
    ev_stop_done |=> fl_q[FLG_STOP] && !stop_req_q
      && st_q == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop completion wrong");

  property p_rx;
    ev_rx_byte |=> fl_q[FLG_RXF]
      && rxd_q == $past({sh_q[6:0], sda_in});
  endproperty
  a_rx: assert property (p_rx)
    else $error("received byte not flagged");

  property p_nack_bit;
    ev_rx_byte && $past(nack_req_q) && nack_req_q |=> !sda_low_q;
  endproperty
  a_nack_bit: assert property (p_nack_bit)
    else $error("nack not returned");

  property p_srst;
    srst |=> st_q == ST_IDLE && scl_oe_n && sda_oe_n
      && !start_req_q && !stop_req_q;
  endproperty
  a_srst: assert property (p_srst)
    else $error("soft reset left engine active");

  property p_w1c;
    fl_clr[FLG_START] && !fl_set[FLG_START] |=> !fl_q[FLG_START];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear flag");
endmodule

// ---- rtl/itm_pkg.sv ----
// itm_pkg: shared constants of the two-wire master transfer engine
// assumes a 250 MHz pclk and a 32-bit apb register bus
package itm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BAUD = 8'h04;
  localparam logic [7:0] OFS_FLAG = 8'h08;
  localparam logic [7:0] OFS_TXD  = 8'h0C;
  localparam logic [7:0] OFS_RXD  = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h14;
  // control_reg bits
  localparam int CTL_EN   = 0;
  localparam int CTL_SRST = 1;
  localparam int CTL_MST  = 2;
  localparam int CTL_STA  = 3;
  localparam int CTL_STO  = 4;
  localparam int CTL_NAK  = 5;
  // irq_flag_reg bits, the first five form the flag vector
  localparam int FLG_START = 0;
  localparam int FLG_STOP  = 1;
  localparam int FLG_NACK  = 2;
  localparam int FLG_TXE   = 3;
  localparam int FLG_RXF   = 4;
  localparam int FLG_BUSY  = 5;
  localparam int FLG_N     = 5;
  // mode_reg fields
  localparam int MODE_LONG = 0;
  localparam int MODE_GENERAL_CALL_ENABLE = 1;
  localparam int MODE_OA   = 16;
  localparam int OA_W      = 10;
  // baud generator: half period is divisor plus three
  localparam int BRT_W = 7;
  localparam logic [7:0] BRT_ADD = 8'h03;
  localparam logic [6:0] BRT_RST = 7'h01;
  // bus free time after stop
  localparam int CLK_MHZ = 250;
  localparam int TBUF_NS = 4700;
  localparam int TBUF_CYC = (TBUF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [10:0] TBUF_LAST = 11'(TBUF_CYC - 1);
  // sequencing constants
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [1:0] STEP_RS   = 2'h0;
  localparam logic [1:0] STEP_IDLE = 2'h2;
  localparam logic [1:0] STEP_STO  = 2'h2;
  localparam int DIR_BIT = 0;
  localparam logic [7:0] RX_FILL = 8'hFF;
  localparam logic PIN_LOW = 1'b0;
  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_START = 7'h02,
    ST_HOLD  = 7'h04,
    ST_BIT   = 7'h08,
    ST_ACK   = 7'h10,
    ST_STOP  = 7'h20,
    ST_BUF   = 7'h40
  } itm_state_e;
endpackage

// ---- rtl/itm_brg_if.sv ----
// itm_brg_if: link between the engine and its baud generator
// assumes both ends sit in the pclk domain
`timescale 1ns/1ns
interface itm_brg_if;
  logic       run;
  logic [6:0] div;
  logic       gen_clk;
  logic       pin_clk;
  logic       tick;
  modport eng (output run, div, gen_clk, pin_clk, input tick);
  modport gen (input run, div, gen_clk, pin_clk, output tick);
endinterface

// ---- rtl/itm_brg.sv ----
// itm_brg: half-period tick generator with clock stretch pause
// assumes the pin level is already synchronous to pclk
`timescale 1ns/1ns
module itm_brg
  import itm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  itm_brg_if.gen   bi
);
  logic [7:0] cnt_q;
  logic [7:0] half;
  logic       pause;

  // pause while the driven level and the pin disagree
  assign half  = {1'b0, bi.div} + BRT_ADD;
  assign pause = bi.gen_clk != bi.pin_clk;
  assign bi.tick = bi.run && !pause && (cnt_q == half - 8'h01);

  // half-period counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 8'h00;
    else if (!bi.run || bi.tick)
      cnt_q <= 8'h00;
    else if (!pause)
      cnt_q <= cnt_q + 8'h01;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pause;
    bi.run && pause |=> !bi.run || cnt_q == $past(cnt_q);
  endproperty
  a_pause: assert property (p_pause)
    else $error("baud count moved during stretch");

  property p_min_half;
    $rose(bi.run) |-> !bi.tick ##1 !bi.tick ##1 !bi.tick;
  endproperty
  a_min_half: assert property (p_min_half)
    else $error("half period shorter than four cycles");
endmodule

// ---- dv/itm_slave.sv ----
// itm_slave: behavioural target on the two-wire bus
// assumes pulled-up wires resolved by the bench, pclk oversampling
`timescale 1ns/1ns
module itm_slave
  import itm_pkg::*;
#(
  parameter logic [6:0] ADDR  = 7'h2a,
  parameter logic [7:0] DATA0 = 8'ha5
)(
  input  wire logic  pclk,
  input  wire logic  presetn,
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  slow,
  output logic       scl_low,
  output logic       sda_low,
  output logic       got_v,
  output logic [7:0] got,
  output logic [1:0] acks
);
  logic       scl_p, sda_p, act, rd, adr;
  logic [3:0] cnt;
  logic [7:0] sh, nxt;
  logic [4:0] hold;
  // follow bus events and answer on clock falls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {scl_p, sda_p, act, rd, adr, scl_low, sda_low} <= 7'h60;
      {got_v, got, acks, cnt, sh, hold} <= '0;
      nxt <= DATA0;
    end
    else
    begin
      scl_p <= scl;
      sda_p <= sda;
      got_v <= 1'b0;
      // stretch for a while when slow, then let go
      if (hold != 5'h0) hold <= hold - 5'h1;
      else scl_low <= 1'b0;
      if (scl && scl_p && sda_p && !sda)
      begin
        {act, adr, rd, sda_low} <= 4'hc;
        cnt <= 4'h0;
      end
      else if (scl && scl_p && !sda_p && sda)
        {act, sda_low} <= 2'h0;
      else if (act && scl && !scl_p)
      begin
        // sample data when receiving, master ack when sending
        if (cnt < 4'h8 && !rd) sh <= {sh[6:0], sda};
        if (cnt == 4'h8 && rd) acks <= {acks[0], sda};
        if (cnt == 4'h8 && rd && sda) act <= 1'b0;
        cnt <= cnt + 4'h1;
      end
      else if (act && !scl && scl_p)
      begin
        if (cnt == 4'h8 && rd) sda_low <= 1'b0;
        else if (cnt == 4'h8)
        begin
          // ack matching address and every written byte
          sda_low <= !adr || sh[7:1] == ADDR;
          act <= !adr || sh[7:1] == ADDR;
          got <= sh;
          got_v <= !adr;
          if (adr) rd <= sh[0];
          adr <= 1'b0;
        end
        else if (cnt == 4'h9)
        begin
          cnt <= 4'h0;
          scl_low <= slow;
          hold <= 5'd20;
          sh <= nxt;
          if (rd) nxt <= nxt + 8'h1; // only sent bytes advance
          sda_low <= rd && !nxt[7];
        end
        else if (rd && cnt != 4'h0) sda_low <= !sh[3'(4'h7 - cnt)];
      end
    end
  end
endmodule

// ---- dv/itm_engine_bench.sv ----
// itm_engine_bench: apb-driven checks of the transfer engine
// assumes one pull-up on each wire and the slave model beside it
`timescale 1ns/1ns
module itm_engine_bench;
  import itm_pkg::*;
  localparam logic [6:0] SA = 7'h2a;
  localparam logic [7:0] D0 = 8'ha5;
  logic        pclk, presetn, psel, penable, pwrite, ck, slow;
  logic [7:0]  paddr, bd, got;
  logic [31:0] pwdata, prdata, r, md;
  logic        pready, pslverr, scl_out, sda_out, scl_oe_n, sda_oe_n;
  logic        s_scl, s_sda, got_v, scl_w, sda_w, se;
  logic [1:0]  acks;
  logic [63:0] qr[$];
  logic [63:0] nt;
  logic [31:0] qb[$];
  int          n_fail, num_checks, cyc;
  // open-drain wires: low if anyone pulls
  assign scl_w = scl_oe_n && !s_scl;
  assign sda_w = sda_oe_n && !s_sda;
  itm_engine itm_engine_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n));
  itm_slave #(.ADDR(SA), .DATA0(D0)) itm_slave_inst (
    .pclk(pclk), .presetn(presetn), .scl(scl_w), .sda(sda_w),
    .slow(slow), .scl_low(s_scl), .sda_low(s_sda), .got_v(got_v),
    .got(got), .acks(acks));
  // clock and time limit
  always #2 pclk = !pclk;
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      final_report;
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, e, input string n);
    num_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // watcher: oldest note against each rc read and each slave data byte
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite && ck)
    begin
      nt = qr.pop_front();
      chk(prdata & nt[63:32], nt[31:0], "prdata");
    end
    if (got_v) chk({24'h0, got}, qb.pop_front(), "slave byte");
  end
  // one apb transfer, held until pready is seen high
  task automatic xf(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic c);
    @(posedge pclk);
    {psel, penable, pwrite, ck} <= {2'b10, w, c};
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    {psel, penable, ck} <= 3'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xf(1'b1, a, d, 1'b0);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, m);
    qr.push_back({m, e});
    xf(1'b0, a, 32'h0, 1'b1);
  endtask
  // poll a flag bit under a bound
  task automatic wf(input int b);
    int i;
    i = 0;
    do
    begin
      xf(1'b0, OFS_FLAG, 32'h0, 1'b0);
      i++;
    end
    while (r[b] !== 1'b1 && i < 3000);
    chk({31'h0, r[b]}, 32'h1, "flag wait");
  endtask
  task automatic go(input logic [7:0] a);
    wr(OFS_CTRL, 32'h0000_000d);
    wf(FLG_START);
    wr(OFS_FLAG, 32'h0000_0001);
    wr(OFS_TXD, {24'h0, a});
  endtask
  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, ck, slow} = '0;
    {paddr, pwdata, n_fail, num_checks, cyc} = '0;
    void'($urandom(20));
    bd = 8'(1 + $urandom % 4);
    md = {6'h0, 10'($urandom), 14'h0, 2'h3};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rc(OFS_BAUD, 32'h0000_0001, 32'h0000_007f);
    rc(OFS_FLAG, 32'h0, 32'h0000_003f);
    rc(8'h20, 32'h0, 32'hffff_ffff);
    chk({31'h0, se}, 32'h1, "pslverr");
    wr(OFS_BAUD, {24'h0, bd});
    rc(OFS_BAUD, {24'h0, bd}, 32'h0000_007f);
    chk({31'h0, se}, 32'h0, "pslverr");
    wr(OFS_MODE, md);
    rc(OFS_MODE, md, 32'h03ff_0003);
    wr(OFS_CTRL, 32'h0000_0003);
    rc(OFS_CTRL, 32'h0000_0001, 32'h0000_003d);
    wr(OFS_CTRL, 32'h0000_0007);
    wr(OFS_CTRL, 32'h0000_000d);
    wf(FLG_START);
    rc(OFS_FLAG, 32'h0000_0009, 32'h0000_001f);
    rc(OFS_CTRL, 32'h0000_0005, 32'h0000_003d);
    wr(OFS_FLAG, 32'h0000_0001);
    rc(OFS_FLAG, 32'h0000_0008, 32'h0000_001f);
    wr(OFS_TXD, {24'h0, SA, 1'b0});
    wf(FLG_TXE);
    repeat (2)
    begin
      qb.push_back(32'($urandom % 256));
      wr(OFS_TXD, qb[$]);
      wf(FLG_TXE);
    end
    repeat (40) @(posedge pclk);
    chk({31'h0, scl_w}, 32'h0, "scl hold");
    chk({30'h0, scl_out, sda_out}, 32'h0, "drive level");
    go({~SA, 1'b0});
    wf(FLG_NACK);
    rc(OFS_FLAG, 32'h0000_0004, 32'h0000_001f);
    wr(OFS_FLAG, 32'h0000_0004);
    slow <= 1'b1;
    go({SA, 1'b1});
    wf(FLG_RXF);
    repeat (60) @(posedge pclk);
    chk({31'h0, scl_w}, 32'h0, "scl rx hold");
    wr(OFS_CTRL, 32'h0000_0025);
    rc(OFS_RXD, {24'h0, D0}, 32'h0000_00ff);
    wf(FLG_RXF);
    repeat (60) @(posedge pclk);
    chk({30'h0, acks}, 32'h1, "master acks");
    rc(OFS_RXD, {24'h0, D0 + 8'h1}, 32'h0000_00ff);
    wr(OFS_CTRL, 32'h0000_0015);
    rc(OFS_FLAG, 32'h0, 32'h0000_0002);
    wf(FLG_STOP);
    rc(OFS_CTRL, 32'h0000_0005, 32'h0000_003d);
    chk({30'h0, scl_w, sda_w}, 32'h3, "stop lines");
    wr(OFS_FLAG, 32'h0000_0002);
    rc(OFS_FLAG, 32'h0, 32'h0000_001f);
    slow <= 1'b0;
    go({~SA, 1'b1});
    wf(FLG_NACK);
    wr(OFS_FLAG, 32'h0000_0004);
    wr(OFS_CTRL, 32'h0000_0015);
    wf(FLG_STOP);
    wr(OFS_FLAG, 32'h0000_0002);
    go({SA, 1'b0});
    repeat (10) @(posedge pclk);
    wr(OFS_CTRL, 32'h0000_0007);
    repeat (4) @(posedge pclk);
    chk({30'h0, scl_w, sda_w}, 32'h3, "reset lines");
    rc(OFS_FLAG, 32'h0, 32'h0000_0020);
    rc(OFS_CTRL, 32'h0, 32'h0000_0038);
    final_report;
  end
endmodule
